// file: hdl/scm_top.sv
// What this block does
// - Switch 5 change during init opens menu
// - Menu: switch 1 starts hold-time adjust
// - Hold time steps 0.2 to 5 s
// - Adjusting hold: relay toggles, LED alternates
// - Second switch 1 change stores hold time
// - After storing, switch 5 leaves menu
// - Switch 2 adjusts, shows, stores immunity
// - Switch 3 then 1: open-door field adjust
// - Switch 1 then 3 stores open field
// - Switch 3/2 enters, 2/3 stores closed field
// - Switch 4 flashes red, back restores defaults
// - Active closes contact, passive opens on detect
// - Switch up reads ON, down OFF
// - On remote variant switches need switch 6
// - Switch 6 off enables remote programming
// - Remote: ignore pot, switch 5; address 1-4
// - Remote mode keeps detecting and switching relay
// - Pot clockwise enlarges sensing area
// - Closed-door slow mode triggers near door
// - Init flashes red/green ten seconds, then status
// - Immunity from 1 to 7
module scm_top #(
  parameter int MS_CYC  = scm_pkg::MS_CYC,
  parameter int INIT_MS = scm_pkg::INIT_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  sw_pin,
  input  wire logic [7:0]  pot_pin,
  input  wire logic        motion_pin,
  input  wire logic        slow_near_pin,
  output logic             relay_closed,
  output logic             led_red,
  output logic             led_green,
  output logic [3:0]       sens_level,
  output logic [1:0]       det_mode,
  output logic             xmask_en,
  output logic             turtle_open_en,
  output logic [3:0]       imm_level,
  output logic [3:0]       fopen_level,
  output logic [3:0]       fclosed_level
);
  import scm_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sw_m, sw_s;     // Switches, 1 = up = ON
  logic [7:0] pot_m, pot_s;   // Pot ADC word, slow-moving
  logic [1:0] det_m, det_s;   // Motion, slow-near flags

  // Two stages; first stage read only by second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_m  <= 6'h00;
      sw_s  <= 6'h00;
      pot_m <= 8'h00;
      pot_s <= 8'h00;
      det_m <= 2'h0;
      det_s <= 2'h0;
    end else begin
      sw_m  <= sw_pin;
      sw_s  <= sw_m;
      pot_m <= pot_pin;
      pot_s <= pot_m;
      det_m <= {slow_near_pin, motion_pin};
      det_s <= det_m;
    end
  end

  // ---------------------------------------------------------------
  // Millisecond and blink ticks
  // ---------------------------------------------------------------
  logic [16:0] ms_reg;        // Cycle count within 1 ms
  logic [7:0]  fl_reg;        // ms within blink half period
  logic [3:0]  frame_reg;     // Blink steps, level display frame
  wire         ms_tick = (ms_reg == 17'(MS_CYC - 1));
  wire         fl_tick = ms_tick && (fl_reg == 8'(FLASH_MS - 1));
  wire         blink   = frame_reg[0];

  // Free-running dividers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_reg    <= 17'h0;
      fl_reg    <= 8'h00;
      frame_reg <= 4'h0;
    end else begin
      ms_reg <= ms_tick ? 17'h0 : ms_reg + 17'h1;
      if (ms_tick)
        fl_reg <= fl_tick ? 8'h00 : fl_reg + 8'h01;
      if (fl_tick)
        frame_reg <= frame_reg + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Switch debouncing
  // ---------------------------------------------------------------
  logic [5:0] stab_reg;       // Debounced levels
  logic [5:0] tog_reg;        // One-cycle toggle pulses
  logic [4:0] deb_reg [6];    // Per-switch stability counters
  logic [2:0] first_reg;      // Adopt levels until sync stages fill

  // A switch must hold its new level through DEB_MS ms ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_reg  <= 6'h00;
      tog_reg   <= 6'h00;
      first_reg <= 3'h7;
      for (int i = 0; i < 6; i++)
        deb_reg[i] <= 5'h00;
    end else begin
      tog_reg   <= 6'h00;
      first_reg <= {first_reg[1:0], 1'b0};
      // Power-up position is not a toggle; the synchroniser still
      // holds its reset zeros for two edges, so keep adopting
      if (first_reg != 3'h0)
        stab_reg <= sw_s;
      else for (int i = 0; i < 6; i++) begin
        if (sw_s[i] == stab_reg[i]) begin
          deb_reg[i] <= 5'h00;
        end else if (ms_tick) begin
          if (deb_reg[i] == 5'(DEB_MS - 1)) begin
            stab_reg[i] <= sw_s[i];
            tog_reg[i]  <= 1'b1;
            deb_reg[i]  <= 5'h00;
          end else begin
            deb_reg[i] <= deb_reg[i] + 5'h01;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [31:0] ctrl_reg;      // Variant flag
  logic [31:0] rcfg_reg;      // Remote settings
  logic [7:0]  prof_reg [16]; // Profile lookup table
  logic [2:0]  hold_reg;      // Stored hold step
  logic [3:0]  imm_reg;       // Stored immunity
  logic [3:0]  fo_reg;        // Stored open-door field
  logic [3:0]  fc_reg;        // Stored closed-door field

  // Bus decode
  wire setup   = psel && !penable;
  wire acc     = psel && penable && pready;
  wire hit_ctl = (paddr == A_CTRL);
  wire hit_rc  = (paddr == A_RCFG);
  wire hit_nv  = (paddr == A_NV);
  wire hit_st  = (paddr == A_STAT);
  wire hit_pr  = (paddr[7:6] == 2'h1) && (paddr[1:0] == 2'h0);
  wire hit_any = hit_ctl || hit_rc || hit_nv || hit_st || hit_pr;
  wire [3:0] pidx = paddr[5:2];

  // ---------------------------------------------------------------
  // Operating mode
  // ---------------------------------------------------------------
  // Remote variant with switch 6 off hands settings to remote
  wire remote = ctrl_reg[CTRL_RC] && !stab_reg[5];
  wire [7:0] prof = prof_reg[stab_reg[3:0]];
  wire [3:0] pot_sens = band(pot_s, N_SENS);
  wire [3:0] pot_hold = band(pot_s, N_HOLD);
  wire [3:0] pot_imm  = band(pot_s, N_IMM) + 4'h1;
  wire [3:0] pot_fld  = band(pot_s, N_FLD) + 4'h1;
  // Remote ignores pot and switch profile
  wire [3:0] sens_nx = remote ? rcfg_reg[RC_SENS +: 4]
                              : pot_sens;
  wire [1:0] det_nx  = remote ? rcfg_reg[RC_DET +: 2]
                              : prof[PR_DET +: 2];
  wire       xm_nx   = remote ? rcfg_reg[RC_XM] : prof[PR_XM];
  wire       to_nx   = remote ? rcfg_reg[RC_TO] : prof[PR_TO];
  wire       tc_nx   = remote ? rcfg_reg[RC_TC] : prof[PR_TC];
  // Switch 5 up selects active contact
  wire       pass_nx = remote ? rcfg_reg[RC_PASS]
                              : !stab_reg[4];

  // ---------------------------------------------------------------
  // Menu state machine
  // ---------------------------------------------------------------
  scm_state_t  st_reg, st_next;
  logic [13:0] init_reg;      // ms since restart
  wire t1 = tog_reg[0];
  wire t2 = tog_reg[1];
  wire t3 = tog_reg[2];
  wire t4 = tog_reg[3];
  wire t5 = tog_reg[4] && !remote;
  wire init_done = ms_tick && (init_reg == 14'(INIT_MS - 1));

  // Stores and factory reload
  wire sv_hold = (st_reg == S_HOLD) && t1;
  wire sv_imm  = (st_reg == S_IMM) && t2;
  wire sv_fo   = (st_reg == S_FOPS) && t3;
  wire sv_fc   = (st_reg == S_FCLS) && t3;
  wire factory = (st_reg == S_FRST) && t4;

  // Next state; one toggle per cycle in practice
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      S_INIT: begin
        if (t5)
          st_next = S_MENU;
        else if (init_done)
          st_next = S_NORM;
      end
      S_MENU: begin
        if (t5)
          st_next = S_NORM;
        else if (t1)
          st_next = S_HOLD;
        else if (t2)
          st_next = S_IMM;
        else if (t3)
          st_next = S_SEL3;
        else if (t4)
          st_next = S_FRST;
      end
      S_SEL3: begin
        if (t1)
          st_next = S_FOP;
        else if (t2)
          st_next = S_FCL;
      end
      S_HOLD: if (sv_hold) st_next = S_MENU;
      S_IMM:  if (sv_imm) st_next = S_MENU;
      S_FOP:  if (t1) st_next = S_FOPS;
      S_FOPS: if (sv_fo) st_next = S_MENU;
      S_FCL:  if (t2) st_next = S_FCLS;
      S_FCLS: if (sv_fc) st_next = S_MENU;
      S_FRST: if (factory) st_next = S_INIT;
      default: st_next = st_reg;
    endcase
  end

  // State and init timer; factory reload restarts the timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= S_INIT;
      init_reg <= 14'h0;
    end else begin
      st_reg <= st_next;
      if (factory)
        init_reg <= 14'h0;
      else if (ms_tick && st_reg == S_INIT && !init_done)
        init_reg <= init_reg + 14'h1;
    end
  end

  // ---------------------------------------------------------------
  // Relay timing
  // ---------------------------------------------------------------
  logic [12:0] hold_cnt;      // Off-delay remaining, ms
  logic [12:0] demo_cnt;      // Demo toggle timer, ms
  logic        demo_reg;      // Demo relay phase
  // Slow approach near closed door also triggers
  wire det_now = det_s[0] || (tc_nx && det_s[1]);
  wire det_act = det_now || (hold_cnt != 13'h0);
  wire [12:0] demo_ms = hold_ms(pot_hold[2:0]) - 13'h1;

  // Detection keeps running in every mode, remote included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 13'h0;
      demo_cnt <= 13'h0;
      demo_reg <= 1'b0;
    end else begin
      if (det_now)
        hold_cnt <= hold_ms(hold_reg);
      else if (ms_tick && hold_cnt != 13'h0)
        hold_cnt <= hold_cnt - 13'h1;
      // Demo runs at the pot-selected time
      if (st_reg != S_HOLD) begin
        demo_cnt <= 13'h0;
        demo_reg <= 1'b0;
      end else if (ms_tick) begin
        if (demo_cnt >= demo_ms) begin
          demo_cnt <= 13'h0;
          demo_reg <= !demo_reg;
        end else begin
          demo_cnt <= demo_cnt + 13'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // LED and relay pattern
  // ---------------------------------------------------------------
  logic [3:0] lvl;            // Level being shown
  logic       red_nx, grn_nx, rel_nx;
  wire        lvl_on = (frame_reg < lvl);

  // Level display: red for lvl blink steps of each frame
  always_comb begin
    lvl    = 4'h0;
    red_nx = 1'b0;
    grn_nx = 1'b0;
    rel_nx = det_act ^ pass_nx;
    case (st_reg)
      S_INIT: begin
        red_nx = blink;
        grn_nx = !blink;
      end
      S_NORM: begin
        red_nx = det_act;
        grn_nx = !det_act;
      end
      S_HOLD: begin
        red_nx = demo_reg;
        grn_nx = !demo_reg;
        rel_nx = demo_reg;
      end
      S_IMM: begin
        lvl    = pot_imm;
        red_nx = lvl_on;
        grn_nx = !lvl_on;
      end
      S_FOP, S_FCL: begin
        lvl    = pot_fld;
        red_nx = lvl_on;
        grn_nx = !lvl_on;
      end
      S_FRST: red_nx = blink;
      default: grn_nx = blink;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers and bus answer
  // ---------------------------------------------------------------
  logic [31:0] rd_nx;
  always_comb begin
    rd_nx = 32'h0;
    if (hit_ctl)
      rd_nx = ctrl_reg;
    else if (hit_rc)
      rd_nx = rcfg_reg;
    else if (hit_nv)
      rd_nx = {16'h0, fc_reg, fo_reg, imm_reg, 1'b0, hold_reg};
    else if (hit_st)
      rd_nx = {14'h0, relay_closed, det_act, sens_level,
               stab_reg[3:0], 3'h0, remote, st_reg};
    else if (hit_pr)
      rd_nx = {24'h0, prof_reg[pidx]};
  end

  // No wait state: ready follows setup by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hit_any;
      if (setup && !pwrite)
        prdata <= rd_nx;
    end
  end

  // Software-writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST;
      rcfg_reg <= RCFG_RST;
      for (int i = 0; i < 16; i++)
        prof_reg[i] <= 8'h00;
    end else if (acc && pwrite) begin
      if (hit_ctl)
        ctrl_reg <= {31'h0, pwdata[CTRL_RC]};
      else if (hit_rc)
        rcfg_reg <= {22'h0, pwdata[9:0]};
      else if (hit_pr)
        prof_reg[pidx] <= {3'h0, pwdata[4:0]};
    end
  end

  // Stored settings, reloaded by factory reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= DEF_HOLD;
      imm_reg  <= DEF_IMM;
      fo_reg   <= DEF_FLD;
      fc_reg   <= DEF_FLD;
    end else if (factory) begin
      hold_reg <= DEF_HOLD;
      imm_reg  <= DEF_IMM;
      fo_reg   <= DEF_FLD;
      fc_reg   <= DEF_FLD;
    end else begin
      if (sv_hold)
        hold_reg <= pot_hold[2:0];
      if (sv_imm)
        imm_reg <= pot_imm;
      if (sv_fo)
        fo_reg <= pot_fld;
      if (sv_fc)
        fc_reg <= pot_fld;
    end
  end

  // Registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_closed   <= 1'b0;
      led_red        <= 1'b0;
      led_green      <= 1'b0;
      sens_level     <= 4'h0;
      det_mode       <= 2'h0;
      xmask_en       <= 1'b0;
      turtle_open_en <= 1'b0;
      imm_level      <= DEF_IMM;
      fopen_level    <= DEF_FLD;
      fclosed_level  <= DEF_FLD;
    end else begin
      relay_closed   <= rel_nx;
      led_red        <= red_nx;
      led_green      <= grn_nx;
      sens_level     <= sens_nx + 4'h0;
      det_mode       <= det_nx;
      xmask_en       <= xm_nx;
      turtle_open_en <= to_nx;
      imm_level      <= imm_reg;
      fopen_level    <= fo_reg;
      fclosed_level  <= fc_reg;
    end
  end

endmodule

// file: shared/scm_pkg.sv
package scm_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS   = 10;        // Clock period, ns
  localparam int MS_NS    = 1_000_000; // One millisecond, ns
  localparam int MS_CYC   = (MS_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_MS  = 10_000;    // Power-up flash phase, ms
  localparam int DEB_MS   = 20;        // Switch must stand this long
  localparam int FLASH_MS = 250;       // LED blink half period, ms

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00; // Variant strap copy
  localparam logic [7:0] A_RCFG = 8'h04; // Remote-programmed settings
  localparam logic [7:0] A_NV   = 8'h08; // Stored menu settings
  localparam logic [7:0] A_STAT = 8'h0c; // Live state
  localparam logic [7:0] A_PROF = 8'h40; // 16 profile words, to 0x7c

  // Field positions
  localparam int CTRL_RC   = 0;  // 1: remote-capable variant
  localparam int RC_SENS   = 0;  // [3:0] sensitivity minus one
  localparam int RC_DET    = 4;  // [5:4] detection mode
  localparam int RC_XM     = 6;  // Cross-traffic masking on
  localparam int RC_TO     = 7;  // Slow approach, door open
  localparam int RC_TC     = 8;  // Slow approach, door closed
  localparam int RC_PASS   = 9;  // Passive relay
  localparam int NV_HOLD   = 0;  // [2:0] hold time step
  localparam int NV_IMM    = 4;  // [3:0] immunity 1..7
  localparam int NV_FO     = 8;  // [3:0] open-door field 1..10
  localparam int NV_FC     = 12; // [3:0] closed-door field 1..10
  localparam int PR_DET    = 0;  // [1:0] detection mode
  localparam int PR_XM     = 2;
  localparam int PR_TO     = 3;
  localparam int PR_TC     = 4;
  localparam int ST_STATE  = 0;  // [3:0] menu state
  localparam int ST_REM    = 4;
  localparam int ST_ADDR   = 8;  // [3:0] remote address
  localparam int ST_SENS   = 12; // [3:0] sensitivity minus one, 0..15
  localparam int ST_DET    = 16;
  localparam int ST_RELAY  = 17;

  // Reset and factory values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RCFG_RST = 32'h0000_0037;
  localparam logic [2:0]  DEF_HOLD = 3'h2;
  localparam logic [3:0]  DEF_IMM  = 4'h1;
  localparam logic [3:0]  DEF_FLD  = 4'h5;

  // Number of legal values per adjusted quantity
  localparam logic [4:0] N_HOLD = 5'h08;
  localparam logic [4:0] N_IMM  = 5'h07;
  localparam logic [4:0] N_FLD  = 5'h0a;
  localparam logic [4:0] N_SENS = 5'h10;

  // Menu states, Gray along the usual path
  typedef enum logic [3:0] {
    S_INIT = 4'h0, S_NORM = 4'h1, S_MENU = 4'h3, S_HOLD = 4'h2,
    S_IMM  = 4'h6, S_SEL3 = 4'h7, S_FOP  = 4'h5, S_FOPS = 4'h4,
    S_FCL  = 4'hc, S_FCLS = 4'hd, S_FRST = 4'hf
  } scm_state_t;

  // Split 8-bit pot reading into n equal bands, 0..n-1
  function automatic logic [3:0] band(input logic [7:0] pot,
                                      input logic [4:0] n);
    logic [12:0] p;
    p = 13'(pot) * 13'(n);
    return p[11:8];
  endfunction

  // Relay hold time of a step, in ms
  function automatic logic [12:0] hold_ms(input logic [2:0] idx);
    logic [12:0] t;
    case (idx)
      3'h0:    t = 13'd200;
      3'h1:    t = 13'd500;
      3'h2:    t = 13'd1000;
      3'h3:    t = 13'd1500;
      3'h4:    t = 13'd2000;
      3'h5:    t = 13'd3000;
      3'h6:    t = 13'd4000;
      default: t = 13'd5000;
    endcase
    return t;
  endfunction

endpackage

// file: verif/scm_checker.sv
module scm_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  imm_level,
  input wire logic [3:0]  fopen_level,
  input wire logic [3:0]  fclosed_level
);
  // ----------------------------------------
  // Bus and level checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle of a transfer
  wire setup = psel && !penable;
  ready_next_a: assert property (setup |=> pready)
    else $error("no pready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  ready_cause_a: assert property (pready |-> $past(setup))
    else $error("pready without setup");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  hole_err_a: assert property (setup && paddr == 8'h10 |=> pslverr)
    else $error("unmapped address accepted");
  // The four register words never raise an error
  mapped_ok_a: assert property
    (pslverr |-> !($past(paddr) inside {8'h00, 8'h04, 8'h08, 8'h0c}))
    else $error("error on mapped address");
  rdata_hold_a: assert property ($changed(prdata) |-> $past(setup && !pwrite))
    else $error("read data moved without read");
  imm_range_a: assert property (imm_level inside {[4'h1:4'h7]})
    else $error("immunity out of range");
  field_range_a: assert property
    (fopen_level inside {[4'h1:4'ha]} && fclosed_level inside {[4'h1:4'ha]})
    else $error("field size out of range");
  // Main scenarios reached
  cover property (setup && pwrite);
  cover property (pslverr);
  cover property ($changed(imm_level));
endmodule

bind scm_top scm_checker scm_checker_i (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .imm_level, .fopen_level,
  .fclosed_level);

// file: verif/scm_field.sv
module scm_field (
  input  wire logic       pclk,
  output logic      [5:0] sw_pin,
  output logic      [7:0] pot_pin,
  output logic            motion_pin,
  output logic            slow_near_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Installer side: switches, pot, radar
  // ----------------------------------------
  // All switches up: local mode, active relay
  initial begin
    sw_pin = 6'h3f;
    pot_pin = 8'h00;
    motion_pin = 1'b0;
    slow_near_pin = 1'b0;
  end
  // Chatter three times, ends inverted: one toggle
  task automatic flip(input int n);
    repeat (3) begin
      @(posedge pclk);
      sw_pin[n] <= ~sw_pin[n];
    end
  endtask
  // Slow object near the closed door
  task automatic near(input logic v);
    @(posedge pclk);
    slow_near_pin <= v;
  endtask
  // Turn the pot and set radar motion
  task automatic put(input logic [7:0] pot, input logic mo);
    @(posedge pclk);
    pot_pin <= pot;
    motion_pin <= mo;
  endtask
endmodule

// file: verif/switch_config_menu_test.sv
module switch_config_menu_test import scm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic [5:0]  sw_pin;
  logic [7:0]  pot_pin;
  logic        motion_pin, slow_near_pin, relay_closed, led_red, led_green;
  logic [3:0]  sens_level, imm_level, fopen_level, fclosed_level;
  logic [1:0]  det_mode;
  logic        xmask_en, turtle_open_en;
  int          bad_count = 0;
  int          checks_done = 0;
  // Short ms tick and init phase keep the run brief
  scm_top #(.MS_CYC(10), .INIT_MS(50)) scm_top_i (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sw_pin,
    .pot_pin, .motion_pin, .slow_near_pin, .relay_closed, .led_red,
    .led_green, .sens_level, .det_mode, .xmask_en, .turtle_open_en,
    .imm_level, .fopen_level, .fclosed_level);
  scm_field scm_field_i (.pclk, .sw_pin, .pot_pin, .motion_pin,
    .slow_near_pin);
  always #5 pclk = ~pclk;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk(pready, 1);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read live state until masked bits match, bounded
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while ((rd & m) !== v && n < 4000);
    chk(rd & m, v);
    if ((rd & m) !== v)
      end_sim();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(imm_level, 1);
    chk({fopen_level, fclosed_level}, 8'h55);
    apb(1'b0, A_RCFG, 32'h0);
    chk(rd, RCFG_RST);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    chk(err, 1'b1);
    // Unmapped read answers zero with an error
    apb(1'b0, 8'h10, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask
  task automatic t_menu();
    scm_field_i.flip(4);
    poll(32'hf, 32'h3);
    scm_field_i.put(8'hff, 1'b0);
    scm_field_i.flip(0);
    poll(32'hf, 32'h2);
    chk({relay_closed, led_green}, {led_red, ~led_red});
    scm_field_i.flip(0);
    poll(32'hf, 32'h3);
    apb(1'b0, A_NV, 32'h0);
    chk(rd[2:0], 3'h7);
    scm_field_i.put(8'h80, 1'b0);
    scm_field_i.flip(1);
    poll(32'hf, 32'h6);
    scm_field_i.flip(1);
    poll(32'hf, 32'h3);
    chk(imm_level, 4);
    scm_field_i.flip(3);
    poll(32'hf, 32'hf);
    scm_field_i.flip(3);
    poll(32'hf, 32'h0);
    apb(1'b0, A_NV, 32'h0);
    chk({imm_level, rd[2:0]}, {4'h1, DEF_HOLD});
    scm_field_i.flip(4);
    poll(32'hf, 32'h3);
    scm_field_i.put(8'hff, 1'b0);
    scm_field_i.flip(2);
    poll(32'hf, 32'h7);
    scm_field_i.flip(0);
    poll(32'hf, 32'h5);
    scm_field_i.flip(0);
    poll(32'hf, 32'h4);
    scm_field_i.flip(2);
    poll(32'hf, 32'h3);
    chk(fopen_level, 10);
    scm_field_i.put(8'h00, 1'b0);
    scm_field_i.flip(2);
    poll(32'hf, 32'h7);
    scm_field_i.flip(1);
    poll(32'hf, 32'hc);
    scm_field_i.flip(1);
    poll(32'hf, 32'hd);
    scm_field_i.flip(2);
    poll(32'hf, 32'h3);
    chk(fclosed_level, 1);
    scm_field_i.flip(4);
    poll(32'hf, 32'h1);
  endtask
  // Switch 5 now down: passive contact
  task automatic t_norm();
    scm_field_i.put(8'h80, 1'b1);
    poll(32'h1_0000, 32'h1_0000);
    chk({led_red, led_green}, 2'b10);
    chk(relay_closed, 0);
    chk(sens_level, 8);
    scm_field_i.put(8'hff, 1'b0);
    poll(32'h1_0000, 32'h0);
    chk({sens_level, led_green}, {4'hf, 1'b1});
    // Profile 16: mode 1, masking, both slow-approach modes
    apb(1'b1, A_PROF + 8'h3c, 32'h1d);
    scm_field_i.near(1'b1);
    poll(32'h1_0000, 32'h1_0000);
    chk({det_mode, xmask_en, turtle_open_en}, 4'h7);
    scm_field_i.near(1'b0);
  endtask
  // Remote variant with switch 6 down
  task automatic t_remote();
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_RCFG, 32'h5);
    scm_field_i.put(8'hff, 1'b1);
    scm_field_i.flip(5);
    poll(32'h1_0010, 32'h1_0010);
    chk(rd[11:8], 4'hf);
    chk(sens_level, 5);
    chk({det_mode, xmask_en, turtle_open_en}, 4'h0);
    chk(relay_closed, 1);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_menu();
    t_norm();
    t_remote();
    end_sim();
  end
endmodule
